// ---- src/dbtc_block.sv ----
/*
  Configurable digital block: timer with capture, counter / pwm with an
  enable gate, and dead-band generator, with chained bytes inside one
  instance. Registers are reached over a plain strobe port.
  Assumes the source clock, the previous block's output and the data
  input are levels sampled by the system clock; the data input comes
  from outside and is resynchronised here.
*/
`include "dbtc_defines.svh"

module dbtc_block
  import dbtc_pkg::*;
#(
  parameter int BYTES = 1
) (
  input  wire logic          clock,
  input  wire logic          srst,
  input  wire dbtc_reg_req_t reg_req,
  output logic [7:0]         rd_data,
  input  wire logic          src_clk,
  input  wire logic          data_in,
  input  wire logic          prev_block_in,
  output logic               tc_out,
  output logic               cmp_out,
  output logic               primary_out,
  output logic               deadband_high_side_out,
  output logic               deadband_low_side_out,
  output logic               irq
);

  // --------------------------------------------------------------------
  // sizes and elaboration check
  // --------------------------------------------------------------------
  localparam int W = 8 * BYTES;

  // byte lane field is three bits wide, so at most eight bytes
  if (BYTES < 1 || BYTES > 8) begin : g_bytes_check
    $error("dbtc_block: BYTES must be 1 to 8");
  end

  // --------------------------------------------------------------------
  // state of the block
  // --------------------------------------------------------------------
  typedef struct packed {
    logic [W-1:0] count;
    logic [W-1:0] period;
    logic [W-1:0] compare;
    logic         enable;
    logic [1:0]   func;
    logic         mode_tc;
    logic         mode_le;
    logic         src_prev;
    logic         data_meta;
    logic         data_sync;
    logic         data_prev;
    logic         prev_in_d;
    logic         db_run;
    logic         db_phase;
    logic         db_hi_lvl;
    logic         db_lo_lvl;
    logic         tc;
    logic         cmp;
    logic         db_high;
    logic         db_low;
    logic         irq;
    logic [7:0]   rd;
  } dbtc_state_t;

  dbtc_state_t q;
  dbtc_state_t next_q;

  // --------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------
  // compare-true in either flavour
  function automatic logic cmp_true(
    input logic [W-1:0] cnt,
    input logic [W-1:0] cmpv,
    input logic         le
  );
    logic r;
    r = le ? (cnt <= cmpv) : (cnt < cmpv);
    return r;
  endfunction

  // byte read from a wide register
  function automatic logic [7:0] lane_of(
    input logic [W-1:0] v,
    input logic [2:0]   lane
  );
    logic [7:0] r;
    r = `DBTC_READ_ZERO;
    for (int i = 0; i < BYTES; i++) begin
      if (lane == i[2:0]) begin
        r = v[8*i +: 8];
      end
    end
    return r;
  endfunction

  // --------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------
  logic         tick;
  logic         fall;
  logic         cap_edge;
  logic         sw_cap;
  logic         lane_ok;
  logic         is_zero;
  logic         prev_edge;
  logic         kill;
  logic         pulse_src;
  dbtc_func_t   fsel;

  always_comb begin
    next_q    = q;
    fsel      = dbtc_func_t'(q.func);
    tick      = src_clk & ~q.src_prev;
    fall      = ~src_clk & q.src_prev;
    cap_edge  = q.data_sync & ~q.data_prev;
    is_zero   = (q.count == '0);
    prev_edge = prev_block_in ^ q.prev_in_d;
    kill      = q.data_sync;
    lane_ok   = ({1'b0, reg_req.lane} < 4'(BYTES));
    sw_cap    = 1'b0;
    pulse_src = 1'b0;

    // edge history and the two-stage enable / capture / kill sampler
    next_q.src_prev  = src_clk;
    next_q.prev_in_d = prev_block_in;
    next_q.data_meta = data_in;
    next_q.data_sync = q.data_meta;
    next_q.data_prev = q.data_sync;

    // ------------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------------
    if (reg_req.wr) begin
      unique case (reg_req.sel)
        `DBTC_REG_PERIOD: begin
          for (int i = 0; i < BYTES; i++) begin
            if (reg_req.lane == i[2:0]) begin
              next_q.period[8*i +: 8] = reg_req.wdata;
              // a stopped block takes the new period as its count
              if (!q.enable) begin
                next_q.count[8*i +: 8] = reg_req.wdata;
              end
            end
          end
        end
        `DBTC_REG_COMPARE: begin
          for (int i = 0; i < BYTES; i++) begin
            if (reg_req.lane == i[2:0]) begin
              next_q.compare[8*i +: 8] = reg_req.wdata;
            end
          end
        end
        `DBTC_REG_CONTROL: begin
          if (reg_req.lane == 3'h0) begin
            next_q.enable = reg_req.wdata[`DBTC_CTRL_ENABLE_BIT];
          end
        end
        `DBTC_BLOCK_FUNCTION_SELECT_REG: begin
          if (reg_req.lane == 3'h0) begin
            next_q.mode_tc = reg_req.wdata[`DBTC_FN_MODE0_BIT];
            next_q.mode_le = reg_req.wdata[`DBTC_FN_MODE1_BIT];
            next_q.func    = reg_req.wdata[`DBTC_FN_SEL_MSB:`DBTC_FN_SEL_LSB];
          end
        end
        default: begin
        end
      endcase
    end

    // ------------------------------------------------------------------
    // register reads: data stand one cycle, zero otherwise
    // ------------------------------------------------------------------
    next_q.rd = `DBTC_READ_ZERO;
    if (reg_req.rd && lane_ok) begin
      unique case (reg_req.sel)
        `DBTC_REG_COUNT: begin
          // count reads return zero; outside dead-band use the count goes to compare instead, except on upper-lane reads of a running timer
          next_q.rd = `DBTC_READ_ZERO;
        end
        `DBTC_REG_PERIOD: begin
          next_q.rd = lane_of(q.period, reg_req.lane);
        end
        `DBTC_REG_COMPARE: begin
          next_q.rd = lane_of(q.compare, reg_req.lane);
        end
        `DBTC_REG_CONTROL: begin
          if (reg_req.lane == 3'h0) begin
            next_q.rd = {7'h00, q.enable};
          end
        end
        `DBTC_BLOCK_FUNCTION_SELECT_REG: begin
          if (reg_req.lane == 3'h0) begin
            next_q.rd = {4'h0, q.func, q.mode_le, q.mode_tc};
          end
        end
        default: begin
          next_q.rd = `DBTC_READ_ZERO;
        end
      endcase
    end

    // count read side effects
    if (reg_req.rd && lane_ok && reg_req.sel == `DBTC_REG_COUNT) begin
      if (q.enable && fsel == dbtc_timer) begin
        // only the lowest byte triggers, and it moves every byte
        sw_cap = (reg_req.lane == 3'h0);
      end else if (fsel != dbtc_deadband) begin
        // stopped timer or any counter: copy just the byte read
        for (int i = 0; i < BYTES; i++) begin
          if (reg_req.lane == i[2:0]) begin
            next_q.compare[8*i +: 8] = q.count[8*i +: 8];
          end
        end
      end
    end

    // ------------------------------------------------------------------
    // function logic; the block clock only runs while enabled
    // ------------------------------------------------------------------
    next_q.tc      = 1'b0;
    next_q.cmp     = 1'b0;
    next_q.db_high = 1'b0;
    next_q.db_low  = 1'b0;
    next_q.irq     = 1'b0;

    if (q.enable) begin
      unique case (fsel)
        dbtc_timer: begin
          // whole chained word decrements as one counter
          if (tick) begin
            if (is_zero) begin
              next_q.count = q.period;
            end else begin
              next_q.count = q.count - 1'b1;
            end
          end
          // capture wins over a compare write in the same cycle
          if (cap_edge || sw_cap) begin
            next_q.compare = q.count;
          end
          next_q.tc  = (next_q.count == '0);
          next_q.cmp = cmp_true(next_q.count, q.compare, q.mode_le);
          pulse_src  = q.mode_tc ? (next_q.tc & ~q.tc)
                                 : (next_q.cmp & ~q.cmp);
        end
        dbtc_counter: begin
          if (tick) begin
            // reload at zero even if the enable just fell, then hold
            if (is_zero) begin
              next_q.count = q.period;
            end else if (q.data_sync) begin
              next_q.count = q.count - 1'b1;
            end
          end
          next_q.tc = (next_q.count == '0);
          // pwm output moves only on the source falling edge
          if (fall) begin
            next_q.cmp = cmp_true(q.count, q.compare, q.mode_le);
          end else begin
            next_q.cmp = q.cmp;
          end
          pulse_src = q.mode_tc ? (next_q.tc & ~q.tc)
                                : (next_q.cmp & ~q.cmp);
        end
        dbtc_deadband: begin
          // only the lowest byte is used, so dead time tops out at 256
          if (prev_edge) begin
            next_q.count[7:0] = q.period[7:0];
            next_q.db_run     = 1'b1;
            next_q.db_phase   = prev_block_in;
            if (prev_block_in) begin
              next_q.db_lo_lvl = 1'b0;
            end else begin
              next_q.db_hi_lvl = 1'b0;
            end
          end else if (tick && q.db_run) begin
            if (q.count[7:0] == 8'h00) begin
              next_q.db_run    = 1'b0;
              next_q.db_hi_lvl = q.db_phase;
              next_q.db_lo_lvl = ~q.db_phase;
            end else begin
              next_q.count[7:0] = q.count[7:0] - 8'h01;
            end
          end
          // kill masks outputs but leaves the sequence running
          next_q.db_high = next_q.db_hi_lvl & ~kill;
          next_q.db_low  = next_q.db_lo_lvl & ~kill;
          pulse_src      = next_q.db_high & ~q.db_high;
        end
        default: begin
          pulse_src = 1'b0;
        end
      endcase
    end else begin
      // stopped: levels restart low, count untouched
      next_q.db_run    = 1'b0;
      next_q.db_hi_lvl = 1'b0;
      next_q.db_lo_lvl = 1'b0;
    end

    // one system clock wide interrupt from the chosen edge
    next_q.irq = q.enable & pulse_src;
  end

  // --------------------------------------------------------------------
  // state register
  // --------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (srst) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  // --------------------------------------------------------------------
  // outputs, all straight from flip-flops
  // --------------------------------------------------------------------
  // primary output is the high side in dead-band use
  logic primary_d;

  always_comb begin
    unique case (dbtc_func_t'(next_q.func))
      dbtc_timer:    primary_d = next_q.tc;
      dbtc_counter:  primary_d = next_q.cmp;
      dbtc_deadband: primary_d = next_q.db_high;
      default:       primary_d = 1'b0;
    endcase
  end

  // mirrors the primary choice one flop later than next_q, same cycle as q
  always_ff @(posedge clock) begin
    if (srst) begin
      primary_out <= 1'b0;
    end else begin
      primary_out <= primary_d & next_q.enable;
    end
  end

  assign rd_data                = q.rd;
  assign tc_out                 = q.tc;
  assign cmp_out                = q.cmp;
  assign deadband_high_side_out = q.db_high;
  assign deadband_low_side_out  = q.db_low;
  assign irq                    = q.irq;

endmodule

// ---- src/dbtc_defines.svh ----
/*
  Register indices, field positions and reset values of the timer,
  counter and dead-band block.
  Assumes it is included by bare name wherever these macros are needed.
*/
`ifndef DBTC_DEFINES_SVH
`define DBTC_DEFINES_SVH

// --------------------------------------------------------------------
// register selects (upper address field), byte lane in the lower field
// --------------------------------------------------------------------
`define DBTC_REG_COUNT                     3'h0
`define DBTC_REG_PERIOD                    3'h1
`define DBTC_REG_COMPARE                   3'h2
`define DBTC_REG_CONTROL                   3'h3
`define DBTC_BLOCK_FUNCTION_SELECT_REG     3'h4

// --------------------------------------------------------------------
// field positions and reset values
// --------------------------------------------------------------------
`define DBTC_CTRL_ENABLE_BIT               0
`define DBTC_FN_MODE0_BIT                  0
`define DBTC_FN_MODE1_BIT                  1
`define DBTC_FN_SEL_LSB                    2
`define DBTC_FN_SEL_MSB                    3
`define DBTC_RESET_BYTE                    8'h00
`define DBTC_READ_ZERO                     8'h00

`endif

// ---- src/dbtc_pkg.sv ----
/*
  Types shared by the timer, counter and dead-band block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package dbtc_pkg;

  // --------------------------------------------------------------------
  // function select and register port carrier
  // --------------------------------------------------------------------
  typedef enum logic [1:0] {
    dbtc_timer,
    dbtc_counter,
    dbtc_deadband
  } dbtc_func_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [2:0] sel;
    logic [2:0] lane;
    logic [7:0] wdata;
  } dbtc_reg_req_t;

endpackage

// ---- testbench/dbtc_block_monitor.sv ----
/*
  Port checker for the timer, counter and dead-band block.
  Assumes it is bound to dbtc_block and sees only its ports.
*/
module dbtc_block_monitor
  import dbtc_pkg::*;
#(
  parameter int BYTES = 1
) (
  input wire logic          clock,
  input wire logic          srst,
  input wire dbtc_reg_req_t reg_req,
  input wire logic [7:0]    rd_data,
  input wire logic          src_clk,
  input wire logic          data_in,
  input wire logic          prev_block_in,
  input wire logic          tc_out,
  input wire logic          cmp_out,
  input wire logic          primary_out,
  input wire logic          deadband_high_side_out,
  input wire logic          deadband_low_side_out,
  input wire logic          irq
);
  timeunit 1ns;
  timeprecision 1ps;
  // --------------------------------------------------------------
  // shadow of enable and function, taken from the register port
  // --------------------------------------------------------------
  logic       en;
  logic       mode0;
  logic       src_q;
  logic [1:0] fn;
  wire logic  tick = src_clk && !src_q;
  wire logic  fall = !src_clk && src_q;

  // only lane 0 of control and function is mapped
  always_ff @(posedge clock) begin
    src_q <= src_clk;
    if (srst) begin
      {en, mode0, fn} <= 4'h0;
    end else if (reg_req.wr && reg_req.lane == 3'h0) begin
      if (reg_req.sel == 3'h3) en <= reg_req.wdata[0];
      if (reg_req.sel == 3'h4) {fn, mode0} <= {reg_req.wdata[3:2], reg_req.wdata[0]};
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (srst);

  a_side_overlap: assert property (!(deadband_high_side_out && deadband_low_side_out))
    else $error("both dead-band sides high");
  a_irq_pulse: assert property (irq |=> !irq)
    else $error("irq wider than one cycle");
  a_tc_irq: assert property (en && mode0 && !fn[1] && $rose(tc_out) |-> irq)
    else $error("terminal count rise without irq");
  // two quiet cycles allowed for the registered outputs to drain
  a_quiet_off: assert property (!en && !$past(en) && !$past(en, 2) |->
      !(irq || primary_out || tc_out || cmp_out || deadband_high_side_out
        || deadband_low_side_out))
    else $error("output active while disabled");
  a_count_zero: assert property ($past(reg_req.rd) && $past(reg_req.sel) == 3'h0 |->
      rd_data == 8'h00)
    else $error("count read not zero");
  a_tc_fall: assert property (en && $past(en) && !fn[1] && $fell(tc_out) |-> $past(tick))
    else $error("terminal count fell off a tick");
  a_cmp_fall: assert property (en && $past(en) && fn == 2'h1 && $changed(cmp_out) |->
      $past(fall))
    else $error("counter compare moved off a falling edge");
  a_high_irq: assert property (en && fn == 2'h2 && $rose(deadband_high_side_out) |->
      ##[0:1] irq)
    else $error("high side rise without irq");
endmodule

// ---- testbench/dbtc_block_test.sv ----
/*
  Self-checking bench of the timer, counter and dead-band block.
  Assumes the design, the source model and the checker compile first.
*/
module dbtc_block_test
  import dbtc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // --------------------------------------------------------------
  // stimulus, design and source model
  // --------------------------------------------------------------
  logic          clock;
  logic          srst = 1'b1;
  logic          run = 1'b0;
  logic          data_in = 1'b0;
  logic          prev_block_in = 1'b0;
  logic [3:0]    half = 4'h0;
  dbtc_reg_req_t req = '0;
  logic [7:0]    rd_data;
  logic          src_clk, tc_out, cmp_out, primary_out, db_hi, db_lo, irq;
  int            failures = 0;
  int            n_checks = 0;
  int            cycles = 0;
  int            ticks = 0;
  int            t0;

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  dbtc_block #(.BYTES(2)) dut (.clock(clock), .srst(srst), .reg_req(req),
    .rd_data(rd_data), .src_clk(src_clk), .data_in(data_in),
    .prev_block_in(prev_block_in), .tc_out(tc_out), .cmp_out(cmp_out),
    .primary_out(primary_out), .deadband_high_side_out(db_hi),
    .deadband_low_side_out(db_lo), .irq(irq));
  dbtc_source_model src (.clock(clock), .srst(srst), .run(run), .half(half),
    .src_clk(src_clk));

  // tick tally, and a cap far above the few hundred cycles needed
  always @(posedge src_clk) ticks++;
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      report_and_stop();
    end
  end

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [2:0] sel, input logic [2:0] lane, input logic [7:0] d);
    @(posedge clock);
    req <= '{wr: 1'b1, rd: 1'b0, sel: sel, lane: lane, wdata: d};
    @(posedge clock);
    req <= '0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [2:0] sel, input logic [2:0] lane, input logic [7:0] exp);
    @(posedge clock);
    req <= '{wr: 1'b0, rd: 1'b1, sel: sel, lane: lane, wdata: 8'h00};
    @(posedge clock);
    req <= '0;
    #1 check("rd_data", rd_data, exp);
  endtask

  // bounded wait for irq, or for the low side when on_lo is set
  task automatic wait_on(input logic on_lo);
    int n;
    n = 0;
    do begin
      @(posedge clock);
      #1 n++;
    end while ((on_lo ? db_lo : irq) !== 1'b1 && n < 400);
    check("awaited", {7'h0, on_lo ? db_lo : irq}, 8'h01);
  endtask

  task automatic report_and_stop();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clock);
    srst <= 1'b0;
    for (int s = 1; s < 6; s++) rd(s[2:0], 3'h0, 8'h00);
    rd(3'h1, 3'h2, 8'h00);
    // disabled: period loads the count, count reads copy one lane
    wr(3'h1, 3'h0, 8'h05);
    wr(3'h1, 3'h1, 8'h01);
    rd(3'h0, 3'h1, 8'h00);
    rd(3'h2, 3'h1, 8'h01);
    rd(3'h0, 3'h0, 8'h00);
    rd(3'h2, 3'h0, 8'h05);
    // enabled timer, source stopped: software then hardware capture
    wr(3'h2, 3'h1, 8'hff);
    wr(3'h3, 3'h0, 8'h01);
    rd(3'h0, 3'h0, 8'h00);
    rd(3'h2, 3'h0, 8'h05);
    rd(3'h2, 3'h1, 8'h01);
    wr(3'h2, 3'h0, 8'hff);
    data_in <= 1'b1;
    repeat (6) @(posedge clock);
    data_in <= 1'b0;
    rd(3'h2, 3'h0, 8'h05);
    // periodic terminal count, period 2 gives three ticks
    wr(3'h3, 3'h0, 8'h00);
    wr(3'h4, 3'h0, 8'h01);
    wr(3'h1, 3'h1, 8'h00);
    wr(3'h1, 3'h0, 8'h02);
    wr(3'h3, 3'h0, 8'h01);
    run <= 1'b1;
    wait_on(1'b0);
    check("primary", {7'h0, primary_out}, 8'h01);
    t0 = ticks;
    wait_on(1'b0);
    check("ticks", 8'(ticks - t0), 8'h03);
    // compare irq: less-than rises at zero, less-or-equal at one
    for (int m = 0; m < 2; m++) begin
      @(posedge clock);
      run <= 1'b0;
      wr(3'h3, 3'h0, 8'h00);
      wr(3'h4, 3'h0, {6'h0, m[0], 1'b0});
      wr(3'h1, 3'h0, 8'h02);
      wr(3'h2, 3'h0, 8'h01);
      wr(3'h2, 3'h1, 8'h00);
      wr(3'h3, 3'h0, 8'h01);
      run <= 1'b1;
      wait_on(1'b0);
      check("tc", {7'h0, tc_out}, {7'h0, ~m[0]});
    end
    // counter holds its count with enable low while the source runs
    @(posedge clock);
    run <= 1'b0;
    wr(3'h3, 3'h0, 8'h00);
    wr(3'h4, 3'h0, 8'h04);
    wr(3'h1, 3'h0, 8'h03);
    wr(3'h3, 3'h0, 8'h01);
    run <= 1'b1;
    repeat (20) @(posedge clock);
    run <= 1'b0;
    wr(3'h3, 3'h0, 8'h00);
    rd(3'h0, 3'h0, 8'h00);
    rd(3'h2, 3'h0, 8'h03);
    // count parked at zero with enable low: one reload, then hold
    wr(3'h1, 3'h0, 8'h00);
    wr(3'h3, 3'h0, 8'h01);
    wr(3'h1, 3'h0, 8'h03);
    run <= 1'b1;
    repeat (20) @(posedge clock);
    run <= 1'b0;
    wr(3'h3, 3'h0, 8'h00);
    rd(3'h0, 3'h0, 8'h00);
    rd(3'h2, 3'h0, 8'h03);
    @(posedge clock);
    data_in <= 1'b1;
    wr(3'h3, 3'h0, 8'h01);
    t0 = ticks;
    run <= 1'b1;
    while (ticks - t0 < 5) @(posedge clock);
    run <= 1'b0;
    wr(3'h3, 3'h0, 8'h00);
    data_in <= 1'b0;
    rd(3'h0, 3'h0, 8'h00);
    rd(3'h2, 3'h0, 8'h02);
    // dead band of period 2 from a rising then a falling input
    @(posedge clock);
    half <= 4'h1;
    wr(3'h4, 3'h0, 8'h08);
    wr(3'h1, 3'h0, 8'h02);
    wr(3'h3, 3'h0, 8'h01);
    prev_block_in <= 1'b1;
    repeat (2) @(posedge clock);
    t0 = ticks;
    run <= 1'b1;
    wait_on(1'b0);
    check("dead ticks", 8'(ticks - t0), 8'h03);
    check("low", {7'h0, db_lo}, 8'h00);
    check("primary high", {7'h0, primary_out}, 8'h01);
    @(posedge clock);
    run <= 1'b0;
    prev_block_in <= 1'b0;
    repeat (3) @(posedge clock);
    #1 check("high", {7'h0, db_hi}, 8'h00);
    @(posedge clock);
    run <= 1'b1;
    wait_on(1'b1);
    @(posedge clock);
    data_in <= 1'b1;
    repeat (6) @(posedge clock);
    #1 check("killed", {6'h0, db_hi, db_lo}, 8'h00);
    report_and_stop();
  end
endmodule

bind dbtc_block dbtc_block_monitor #(.BYTES(BYTES)) mon (.clock(clock), .srst(srst),
  .reg_req(reg_req), .rd_data(rd_data), .src_clk(src_clk), .data_in(data_in),
  .prev_block_in(prev_block_in), .tc_out(tc_out), .cmp_out(cmp_out),
  .primary_out(primary_out), .deadband_high_side_out(deadband_high_side_out),
  .deadband_low_side_out(deadband_low_side_out), .irq(irq));

// ---- testbench/dbtc_source_model.sv ----
/*
  Source clock of the neighbouring routing for the block.
  Assumes the bench raises run only when ticks are wanted.
*/
module dbtc_source_model
  import dbtc_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       srst,
  input  wire logic       run,
  input  wire logic [3:0] half,
  output logic            src_clk
);
  timeunit 1ns;
  timeprecision 1ps;
  // --------------------------------------------------------------
  // divided clock, idle low between runs
  // --------------------------------------------------------------
  logic [3:0] cnt;

  // toggles at most every cycle, so ticks never pass 20 MHz
  always @(posedge clock) begin
    if (srst || !run) begin
      src_clk <= 1'b0;
      cnt <= 4'h0;
    end else if (cnt == half) begin
      src_clk <= ~src_clk;
      cnt <= 4'h0;
    end else begin
      cnt <= cnt + 4'h1;
    end
  end
endmodule
